// File: verification/cwgd_assertions.sv
// Purpose: Checker for the waveform pins and the register bus handshakes.
// Assumes: Writes offer address and data together, so both land at once.
// Notes:   Control fields are shadowed from bus writes seen at the ports.
`timescale 1ns/1ns
module cwgd_checker
  import cwgd_pkg::*;
(
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic [31:0]       s_axi_wdata,
  input wire logic [3:0]        s_axi_wstrb,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  input wire logic              drive_out_a,
  input wire logic              drive_out_a_oe,
  input wire logic              drive_out_b,
  input wire logic              drive_out_b_oe
);
  // ****************************************
  // Control shadow
  // ****************************************
  logic [5:0] c0_reg, c0_next;
  logic [4:0] c1_reg, c1_next;
  logic [2:0] age_reg, age_next;
  logic       wr_any, quiet;
  assign wr_any = s_axi_awvalid && s_axi_awready && s_axi_wvalid
                  && s_axi_wready;
  // Pins lag the registers, so checks wait until age saturates
  assign quiet = (age_reg == 3'h7);
  always_comb begin
    c0_next  = c0_reg;
    c1_next  = c1_reg;
    age_next = quiet ? age_reg : age_reg + 3'h1;
    if (wr_any) begin
      age_next = 3'h0;
      if (s_axi_wstrb[0] && s_axi_awaddr == OFS_CTL0)
        c0_next = s_axi_wdata[5:0];
      if (s_axi_wstrb[0] && s_axi_awaddr == OFS_CTL1)
        c1_next = s_axi_wdata[4:0];
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      c0_reg  <= 6'h00;
      c1_reg  <= 5'h00;
      age_reg <= 3'h0;
    end else begin
      c0_reg  <= c0_next;
      c1_reg  <= c1_next;
      age_reg <= age_next;
    end
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid) else $error("write answer dropped early");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer moved");
  a_write_answer: assert property (wr_any |=> s_axi_bvalid)
    else $error("write answer late");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("read answer late");
  a_no_new_write: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready) else $error("write taken too soon");
  a_reset_quiet: assert property ($rose(aresetn) |->
    !drive_out_a_oe && !drive_out_b_oe && !drive_out_a && !drive_out_b)
    else $error("pins active out of reset");
  a_off_when_dis: assert property (quiet && !c0_reg[0] |->
    !drive_out_a_oe && !drive_out_b_oe) else $error("pin driven while off");
  a_own_enable: assert property (quiet && c0_reg[0] |->
    drive_out_a_oe == c0_reg[1] && drive_out_b_oe == c0_reg[2])
    else $error("pin enable wrong");
  a_no_overlap: assert property (
    quiet && c0_reg[0] && !c1_reg[2] |->
    !((drive_out_a ~^ c0_reg[3]) && (drive_out_b ~^ c0_reg[4])))
    else $error("both outputs active");
  a_override_raw: assert property (quiet && c0_reg[2:0] == 3'h7
    && c1_reg[2] |-> drive_out_a == c1_reg[3] && drive_out_b == c1_reg[4])
    else $error("override level wrong");
endmodule : cwgd_checker

bind cwgd_top cwgd_checker u_chk (.*);

// File: verification/cwgd_switch_model.sv
// Purpose: Gate inputs of the external power switches on the two pins.
// Assumes: Each gate input has a pull-down resistor.
// Notes:   A released pin reads low, never the last driven value.
`timescale 1ns/1ns
module cwgd_switch_model (
  input  wire logic a,
  input  wire logic a_oe,
  input  wire logic b,
  input  wire logic b_oe,
  output logic      gate_a,
  output logic      gate_b
);
  // Pull-down keeps a switch off whenever the pin is not driven
  assign gate_a = a_oe ? a : 1'b0;
  assign gate_b = b_oe ? b : 1'b0;
endmodule : cwgd_switch_model

// File: verification/tb_complementary_waveform_deadband.sv
// Purpose: Register access and dead-band timing checks for the generator.
// Assumes: Polarity high and both pins enabled unless a test says otherwise.
// Notes:   Gates are sampled on falling clock edges, away from updates.
`timescale 1ns/1ns
module tb_complementary_waveform_deadband import cwgd_pkg::*;;
  logic              aclk, aresetn, s_axi_awvalid, s_axi_awready;
  logic              s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic              s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic              s_axi_rvalid, s_axi_rready, ga, gb;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0]       s_axi_wdata, s_axi_rdata;
  logic [3:0]        s_axi_wstrb, src;
  logic [1:0]        s_axi_bresp, s_axi_rresp;
  logic              pulse_source_1, pulse_source_2, oscillator_source_out;
  logic              logic_cell_out, internal_fast_oscillator;
  logic              drive_out_a, drive_out_a_oe, drive_out_b, drive_out_b_oe;
  int                error_cnt, checks, cyc, n;
  int                rise_t[4] = '{0, 2, 63, 1};
  int                fall_t[4] = '{5, 0, 1, 63};
  assign {logic_cell_out, oscillator_source_out} = src[3:2];
  assign {pulse_source_2, pulse_source_1} = src[1:0];
  cwgd_top uut (.*);
  cwgd_switch_model sw (.a(drive_out_a), .a_oe(drive_out_a_oe),
    .b(drive_out_b), .b_oe(drive_out_b_oe), .gate_a(ga), .gate_b(gb));
  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [4:0] a, input int d, input logic [1:0] r);
    int k;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    k = 0;
    do begin
      @(posedge aclk);
      k++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && k < 40);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, r);
  endtask : wr
  task automatic rd(input logic [4:0] a, input int e, input logic [1:0] r);
    int k;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    k = 0;
    do begin
      @(posedge aclk);
      k++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && k < 40);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, e);
    chk(s_axi_rresp, r);
  endtask : rd
  // Cycles from the off-going gate falling to the on-going gate rising
  task automatic gap(input logic up, output int c);
    c = 0;
    while ((up ? gb : ga) && c < 200) @(negedge aclk);
    while (!(up ? ga : gb) && c < 200) begin
      @(negedge aclk);
      c++;
    end
  endtask : gap
  task automatic print_verdict;
    $display("checks %0d, mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict
  // ****************************************
  // Stimulus
  // ****************************************
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  // Free-running oscillator near 16 MHz, unrelated to aclk
  initial begin
    internal_fast_oscillator = 1'b0;
    forever #31 internal_fast_oscillator = ~internal_fast_oscillator;
  end
  // A hang counts as a mismatch and ends the run
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      print_verdict();
    end
  end
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
    {s_axi_arvalid, s_axi_rready, src} = 6'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 5; i++) rd(5'(4 * i), 0, RESP_OK);
    rd(5'h14, 0, RESP_ERR);
    wr(5'h14, 1, RESP_ERR);
    $display("test done: registers");
    wr(OFS_CTL0, 32'h1f, RESP_OK);
    src[0] <= 1'b1;
    gap(1'b1, n);
    src[0] <= 1'b0;
    gap(1'b0, n);
    for (int s = 0; s < 4; s++) begin
      wr(OFS_CTL1, s, RESP_OK);
      wr(OFS_RISE, rise_t[s], RESP_OK);
      wr(OFS_FALL, fall_t[s], RESP_OK);
      rd(OFS_FALL, fall_t[s], RESP_OK);
      src[s] <= 1'b1;
      gap(1'b1, n);
      chk(n, rise_t[s]);
      src[s] <= 1'b0;
      gap(1'b0, n);
      chk(n, fall_t[s]);
    end
    $display("test done: dead band");
    wr(OFS_CTL1, 0, RESP_OK);
    wr(OFS_RISE, 10, RESP_OK);
    wr(OFS_FALL, 0, RESP_OK);
    @(posedge aclk) src[0] <= 1'b1;
    repeat (4) @(posedge aclk);
    src[0] <= 1'b0;
    n = 0;
    repeat (40) begin
      @(negedge aclk);
      n += int'(ga);
    end
    chk(n, 0);
    chk(gb, 1'b1);
    // Status: B on, A off, input low, no count running
    rd(OFS_STAT, 32'h02, RESP_OK);
    wr(OFS_STAT, 32'h1f, RESP_OK);
    // Lane 0 strobe low must leave the rising count alone
    s_axi_wstrb <= 4'he;
    wr(OFS_RISE, 1, RESP_OK);
    s_axi_wstrb <= 4'hf;
    rd(OFS_RISE, 10, RESP_OK);
    $display("test done: short pulse");
    wr(OFS_CTL0, 32'h3f, RESP_OK);
    wr(OFS_RISE, 4, RESP_OK);
    src[0] <= 1'b1;
    gap(1'b1, n);
    // Sampled 16 MHz beats against 20 MHz: one tick every 5 or 6 cycles
    chk(n >= 14 && n <= 26, 1'b1);
    $display("test done: clock select");
    wr(OFS_CTL0, 32'h06, RESP_OK);
    // Enables reach the pins one flop after the control register
    repeat (3) @(negedge aclk);
    chk({drive_out_a_oe, drive_out_b_oe}, 2'b00);
    wr(OFS_CTL0, 32'h1f, RESP_OK);
    repeat (3) @(negedge aclk);
    chk({ga, gb}, 2'b00);
    wr(OFS_CTL0, 32'h07, RESP_OK);
    repeat (3) @(negedge aclk);
    chk({drive_out_a, drive_out_b}, 2'b11);
    wr(OFS_CTL1, 32'h14, RESP_OK);
    // Long enough for the checker's settle counter to let override checks in
    repeat (8) @(negedge aclk);
    chk({drive_out_a, drive_out_b}, 2'b01);
    wr(OFS_CTL0, 32'h05, RESP_OK);
    repeat (3) @(negedge aclk);
    chk({drive_out_a_oe, drive_out_b_oe, ga}, 3'b010);
    $display("test done: outputs");
    print_verdict();
  end
endmodule : tb_complementary_waveform_deadband

// File: verilog/cwgd_pkg.sv
// Purpose: Constants and types for the complementary waveform generator.
// Assumes: AXI4-Lite slave with 32-bit data, one clock aclk at 20 MHz.
// Notes:   Operation list below; each item is carried out in cwgd_top.
// Operation
// - Two complementary outputs from one input chosen by a 2-bit select.
// - Dead-band timing uses system clock or 16 MHz oscillator, one select bit.
// - On enable, both A and B drives start cleared.
// - Each output has its own enable; cleared enable leaves the pin undriven.
// - Enabled output shows override value or active waveform.
// - Block enable cleared makes output enables and drive levels ineffective.
// - Per-output polarity bit: set is active-high, cleared is active-low.
// - Polarity applies to the active waveform only, never to override levels.
// - Two 6-bit dead-band counters, one rising edge, one falling edge.
// - Dead band counts clock periods up from zero to the programmed value.
// - Rising edge turns B off at once, A on after rising delay.
// - Rising dead band programmable from zero upward.
// - Zero count means no dead band, incoming output turns on at once.
// - Dead-band timing always starts from the input edge.
// - Input ending before count completes keeps that output off.
package cwgd_pkg;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam int         ADDR_W   = 5;
  localparam int         CNT_W    = 6;
  localparam int         SRC_W    = 5;
  localparam logic [4:0] OFS_CTL0 = 5'h00;
  localparam logic [4:0] OFS_CTL1 = 5'h04;
  localparam logic [4:0] OFS_RISE = 5'h08;
  localparam logic [4:0] OFS_FALL = 5'h0c;
  localparam logic [4:0] OFS_STAT = 5'h10;
  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  localparam logic [5:0] CNT_ZERO = 6'h00;
  localparam logic [5:0] CNT_ONE  = 6'h01;

  // waveform_control_0 fields, bit 5 down to bit 0
  typedef struct packed {
    logic clock_source_select;
    logic out_b_polarity;
    logic out_a_polarity;
    logic out_b_enable;
    logic out_a_enable;
    logic block_enable;
  } cwgd_ctl0_s;

  // waveform_control_1 fields, bit 4 down to bit 0
  typedef struct packed {
    logic       override_b;
    logic       override_a;
    logic       override_on;
    logic [1:0] input_source_select;
  } cwgd_ctl1_s;

  localparam cwgd_ctl0_s CTL0_RST = '0;
  localparam cwgd_ctl1_s CTL1_RST = '0;

endpackage : cwgd_pkg

// File: verilog/cwgd_top.sv
// Purpose: Complementary waveform generator with dead band, AXI4-Lite regs.
// Assumes: Source and oscillator pins are asynchronous to aclk.
// Notes:   Pins see one extra flop of latency; outputs are all registered.
`timescale 1ns/1ns
module cwgd_top
  import cwgd_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              pulse_source_1,
  input  wire logic              pulse_source_2,
  input  wire logic              oscillator_source_out,
  input  wire logic              logic_cell_out,
  input  wire logic              internal_fast_oscillator,
  output logic                   drive_out_a,
  output logic                   drive_out_a_oe,
  output logic                   drive_out_b,
  output logic                   drive_out_b_oe
);

  // ************************************************************
  // Register bus
  // ************************************************************
  cwgd_ctl0_s        ctl0_reg,   ctl0_next;
  cwgd_ctl1_s        ctl1_reg,   ctl1_next;
  logic [CNT_W-1:0]  rise_reg,   rise_next;
  logic [CNT_W-1:0]  fall_reg,   fall_next;
  logic              awgot_reg,  awgot_next;
  logic [ADDR_W-1:0] waddr_reg,  waddr_next;
  logic              wgot_reg,   wgot_next;
  logic [7:0]        wbyte_reg,  wbyte_next;
  logic              wlane_reg,  wlane_next;
  logic              awrdy_reg,  awrdy_next;
  logic              wrdy_reg,   wrdy_next;
  logic              bvalid_reg, bvalid_next;
  logic [1:0]        bresp_reg,  bresp_next;
  logic              arrdy_reg,  arrdy_next;
  logic              rvalid_reg, rvalid_next;
  logic [31:0]       rdata_reg,  rdata_next;
  logic [1:0]        rresp_reg,  rresp_next;
  logic [4:0]        status;

  // Address and data are latched separately, so either may come first
  always_comb begin
    ctl0_next   = ctl0_reg;
    ctl1_next   = ctl1_reg;
    rise_next   = rise_reg;
    fall_next   = fall_reg;
    awgot_next  = awgot_reg;
    waddr_next  = waddr_reg;
    wgot_next   = wgot_reg;
    wbyte_next  = wbyte_reg;
    wlane_next  = wlane_reg;
    bvalid_next = bvalid_reg;
    bresp_next  = bresp_reg;
    rvalid_next = rvalid_reg;
    rdata_next  = rdata_reg;
    rresp_next  = rresp_reg;
    if (awrdy_reg && s_axi_awvalid) begin
      awgot_next = 1'b1;
      waddr_next = s_axi_awaddr;
    end
    if (wrdy_reg && s_axi_wvalid) begin
      wgot_next  = 1'b1;
      wbyte_next = s_axi_wdata[7:0];
      wlane_next = s_axi_wstrb[0];
    end
    if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    // All fields live in byte lane 0; other lanes are ignored
    if (awgot_next && wgot_next && !bvalid_next) begin
      awgot_next  = 1'b0;
      wgot_next   = 1'b0;
      bvalid_next = 1'b1;
      bresp_next  = RESP_OK;
      unique case (waddr_next)
        OFS_CTL0: if (wlane_next) ctl0_next = wbyte_next[5:0];
        OFS_CTL1: if (wlane_next) ctl1_next = wbyte_next[4:0];
        OFS_RISE: if (wlane_next) rise_next = wbyte_next[5:0];
        OFS_FALL: if (wlane_next) fall_next = wbyte_next[5:0];
        OFS_STAT: ;
        default:  bresp_next = RESP_ERR;
      endcase
    end
    awrdy_next = !awgot_next && !bvalid_next;
    wrdy_next  = !wgot_next && !bvalid_next;
    if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
    if (arrdy_reg && s_axi_arvalid) begin
      rvalid_next = 1'b1;
      rresp_next  = RESP_OK;
      unique case (s_axi_araddr)
        OFS_CTL0: rdata_next = 32'(ctl0_reg);
        OFS_CTL1: rdata_next = 32'(ctl1_reg);
        OFS_RISE: rdata_next = 32'(rise_reg);
        OFS_FALL: rdata_next = 32'(fall_reg);
        OFS_STAT: rdata_next = 32'(status);
        default: begin
          rdata_next = '0;
          rresp_next = RESP_ERR;
        end
      endcase
    end
    arrdy_next = !rvalid_next;
  end

  // Bus and configuration registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctl0_reg   <= CTL0_RST;
      ctl1_reg   <= CTL1_RST;
      rise_reg   <= CNT_ZERO;
      fall_reg   <= CNT_ZERO;
      awgot_reg  <= 1'b0;
      waddr_reg  <= '0;
      wgot_reg   <= 1'b0;
      wbyte_reg  <= '0;
      wlane_reg  <= 1'b0;
      awrdy_reg  <= 1'b0;
      wrdy_reg   <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg  <= RESP_OK;
      arrdy_reg  <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg  <= '0;
      rresp_reg  <= RESP_OK;
    end else begin
      ctl0_reg   <= ctl0_next;
      ctl1_reg   <= ctl1_next;
      rise_reg   <= rise_next;
      fall_reg   <= fall_next;
      awgot_reg  <= awgot_next;
      waddr_reg  <= waddr_next;
      wgot_reg   <= wgot_next;
      wbyte_reg  <= wbyte_next;
      wlane_reg  <= wlane_next;
      awrdy_reg  <= awrdy_next;
      wrdy_reg   <= wrdy_next;
      bvalid_reg <= bvalid_next;
      bresp_reg  <= bresp_next;
      arrdy_reg  <= arrdy_next;
      rvalid_reg <= rvalid_next;
      rdata_reg  <= rdata_next;
      rresp_reg  <= rresp_next;
    end
  end

  assign s_axi_awready = awrdy_reg;
  assign s_axi_wready  = wrdy_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = arrdy_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  logic [SRC_W-1:0] pins;
  logic [SRC_W-1:0] sync1_reg;
  logic [SRC_W-1:0] sync2_reg;
  logic             in_prev_reg, in_prev_next;
  logic             osc_prev_reg, osc_prev_next;
  logic             in_level;
  logic             tick;
  logic             rise_edge;
  logic             fall_edge;

  // Bit 0 is the oscillator, bits 1..4 the selectable sources
  assign pins = {logic_cell_out, oscillator_source_out, pulse_source_2,
                 pulse_source_1, internal_fast_oscillator};

  // Two flops per pin; the first stage feeds only the second
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= pins;
      sync2_reg <= sync1_reg;
    end
  end

  // Selected source and its edges
  always_comb begin
    // Widen before the offset so select 3 reaches the last source pin
    in_level      = sync2_reg[3'(ctl1_reg.input_source_select) + 3'h1];
    in_prev_next  = in_level;
    osc_prev_next = sync2_reg[0];
    rise_edge     = in_level && !in_prev_reg;
    fall_edge     = !in_level && in_prev_reg;
    // A sampled oscillator only counts edges aclk can see
    tick = ctl0_reg.clock_source_select ?
           (sync2_reg[0] && !osc_prev_reg) : 1'b1;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      in_prev_reg  <= 1'b0;
      osc_prev_reg <= 1'b0;
    end else begin
      in_prev_reg  <= in_prev_next;
      osc_prev_reg <= osc_prev_next;
    end
  end

  // ************************************************************
  // Dead band and output stage
  // ************************************************************
  logic             a_reg,    a_next;
  logic             b_reg,    b_next;
  logic             rrun_reg, rrun_next;
  logic             frun_reg, frun_next;
  logic [CNT_W-1:0] rcnt_reg, rcnt_next;
  logic [CNT_W-1:0] fcnt_reg, fcnt_next;
  logic             oa_reg,   oa_next;
  logic             ob_reg,   ob_next;
  logic             oea_reg,  oea_next;
  logic             oeb_reg,  oeb_next;

  assign status = {frun_reg, rrun_reg, in_level, b_reg, a_reg};

  // Edges restart timing; counters climb on each dead-band clock tick
  always_comb begin
    a_next    = a_reg;
    b_next    = b_reg;
    rrun_next = rrun_reg;
    frun_next = frun_reg;
    rcnt_next = rcnt_reg;
    fcnt_next = fcnt_reg;
    if (!ctl0_reg.block_enable) begin
      a_next    = 1'b0;
      b_next    = 1'b0;
      rrun_next = 1'b0;
      frun_next = 1'b0;
      rcnt_next = CNT_ZERO;
      fcnt_next = CNT_ZERO;
    end else if (rise_edge) begin
      b_next    = 1'b0;
      frun_next = 1'b0;
      rcnt_next = CNT_ZERO;
      rrun_next = (rise_reg != CNT_ZERO);
      a_next    = (rise_reg == CNT_ZERO);
    end else if (fall_edge) begin
      a_next    = 1'b0;
      rrun_next = 1'b0;
      fcnt_next = CNT_ZERO;
      frun_next = (fall_reg != CNT_ZERO);
      b_next    = (fall_reg == CNT_ZERO);
    end else if (tick) begin
      if (rrun_reg) begin
        rcnt_next = rcnt_reg + CNT_ONE;
        if (rcnt_next == rise_reg) begin
          rrun_next = 1'b0;
          a_next    = 1'b1;
        end
      end
      if (frun_reg) begin
        fcnt_next = fcnt_reg + CNT_ONE;
        if (fcnt_next == fall_reg) begin
          frun_next = 1'b0;
          b_next    = 1'b1;
        end
      end
    end
    // Override bypasses polarity so a safe level is absolute
    oea_next = ctl0_reg.block_enable && ctl0_reg.out_a_enable;
    oeb_next = ctl0_reg.block_enable && ctl0_reg.out_b_enable;
    if (!ctl0_reg.block_enable) begin
      oa_next = 1'b0;
      ob_next = 1'b0;
    end else if (ctl1_reg.override_on) begin
      oa_next = ctl1_reg.override_a;
      ob_next = ctl1_reg.override_b;
    end else begin
      oa_next = a_next ^ !ctl0_reg.out_a_polarity;
      ob_next = b_next ^ !ctl0_reg.out_b_polarity;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      a_reg    <= 1'b0;
      b_reg    <= 1'b0;
      rrun_reg <= 1'b0;
      frun_reg <= 1'b0;
      rcnt_reg <= CNT_ZERO;
      fcnt_reg <= CNT_ZERO;
      oa_reg   <= 1'b0;
      ob_reg   <= 1'b0;
      oea_reg  <= 1'b0;
      oeb_reg  <= 1'b0;
    end else begin
      a_reg    <= a_next;
      b_reg    <= b_next;
      rrun_reg <= rrun_next;
      frun_reg <= frun_next;
      rcnt_reg <= rcnt_next;
      fcnt_reg <= fcnt_next;
      oa_reg   <= oa_next;
      ob_reg   <= ob_next;
      oea_reg  <= oea_next;
      oeb_reg  <= oeb_next;
    end
  end

  assign drive_out_a    = oa_reg;
  assign drive_out_b    = ob_reg;
  assign drive_out_a_oe = oea_reg;
  assign drive_out_b_oe = oeb_reg;

endmodule : cwgd_top
